/* rtl/otprom_host_consts.svh */
`ifndef OTPROM_HOST_CONSTS_SVH
`define OTPROM_HOST_CONSTS_SVH
`define OTPH_PULSE_NS      50000
`define OTPH_CLK_NS        100
`define OTPH_PULSE_CYC     ((`OTPH_PULSE_NS + `OTPH_CLK_NS - 1) / `OTPH_CLK_NS)
`define OTPH_MAX_PULSES    25
`define OTPH_SETTLE_CYC    2
`define OTPH_READ_CYC      2
`define OTPH_PAGE_CYC      1
`define OTPH_ID_LINE       9
`define OTPH_WORDS         524288
`endif

/* rtl/otprom_host_pkg.sv */
package otprom_host_pkg;
   typedef enum logic [3:0] {
      OTPH_IDLE    = 4'h0,
      OTPH_RSETUP  = 4'h1,
      OTPH_RWAIT   = 4'h2,
      OTPH_PSETUP  = 4'h3,
      OTPH_PPULSE  = 4'h4,
      OTPH_PVSETUP = 4'h5,
      OTPH_PVWAIT  = 4'h6,
      OTPH_FSETUP  = 4'h7,
      OTPH_FWAIT   = 4'h8,
      OTPH_DONE    = 4'h9
   } otph_state_t;
   typedef enum logic [1:0] {
      OTPH_CMD_READ = 2'h0,
      OTPH_CMD_PROG = 2'h1,
      OTPH_CMD_ID   = 2'h2,
      OTPH_CMD_FVER = 2'h3
   } otph_cmd_t;
endpackage : otprom_host_pkg

/* rtl/otprom_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "otprom_host_consts.svh"
// Function
// - drive full sixteen-bit word when programming
// - programming supply high, output drive high
// - one fifty-microsecond chip select pulse
// - retry pulses up to twenty-five total
// - pulse-verify every address in sequence
// - final compare at nominal supply level
// - only chip select, output drive per part
// - verify: output drive low, select high
// - identification voltage on ninth address line
// - other address lines low except lowest
// - page reads change only low bits
module otprom_host
   import otprom_host_pkg::*;
#(
   parameter int ADDR_W     = 19,
   parameter int PULSE_CYC  = `OTPH_PULSE_CYC,
   parameter int MAX_PULSES = `OTPH_MAX_PULSES
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              clkEn,
   // command side
   input  wire logic              cmdValid,
   input  wire otph_cmd_t         cmdKind,
   input  wire logic [ADDR_W-1:0] cmdAddr,
   input  wire logic [ADDR_W-1:0] cmdLastAddr,
   input  wire logic              cmdByte,
   input  wire logic              cmdLane,
   input  wire logic [15:0]       cmdData,
   output logic                   cmdReady,
   output logic                   rspValid,
   output logic [15:0]            rspData,
   output logic                   rspError,
   output logic                   rspParityOk,
   // device pins
   output logic [ADDR_W-1:0]      word_addr_lines,
   output logic                   chipSelN,
   output logic                   outDriveN,
   output logic                   widthWord,
   output logic                   progSupplyHigh,
   output logic                   idVoltHigh,
   output logic [14:0]            data_lines_low_o,
   output logic [14:0]            data_lines_low_oe_n,
   input  wire logic [14:0]       data_lines_low_i,
   output logic                   top_data_or_lane_addr_o,
   output logic                   top_data_or_lane_addr_oe_n,
   input  wire logic              top_data_or_lane_addr_i
);
   otph_state_t       state_q;
   otph_cmd_t         kind_q;
   logic [15:0]       cnt_q;
   logic [4:0]        tries_q;
   logic [15:0]       wdata_q;
   logic [ADDR_W-1:0] last_q;
   logic [ADDR_W-1:0] addr_q;
   logic              byte_q;
   logic              lane_q;
   logic              bad_q;

   wire [15:0] pinWord  = {top_data_or_lane_addr_i, data_lines_low_i};
   wire [15:0] pinData  = byte_q ? {8'h00, data_lines_low_i[7:0]} : pinWord;
   // a bit still high where zero was wanted means another pulse
   wire        match    = (pinWord == wdata_q);
   wire        cntDone  = (cnt_q == 16'h0000);
   wire        lastAddr = (addr_q == last_q);
   wire        oddPar   = ^pinWord;
   // identification: only the lowest address line may be set
   wire [ADDR_W-1:0] idAddr = {{(ADDR_W-1){1'b0}}, cmdAddr[0]};

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q                    <= OTPH_IDLE;
         kind_q                     <= OTPH_CMD_READ;
         cnt_q                      <= 16'h0000;
         tries_q                    <= 5'h00;
         wdata_q                    <= 16'h0000;
         last_q                     <= '0;
         addr_q                     <= '0;
         byte_q                     <= 1'b0;
         lane_q                     <= 1'b0;
         bad_q                      <= 1'b0;
         cmdReady                   <= 1'b0;
         rspValid                   <= 1'b0;
         rspData                    <= 16'h0000;
         rspError                   <= 1'b0;
         rspParityOk                <= 1'b0;
         word_addr_lines            <= '0;
         chipSelN                   <= 1'b1;
         outDriveN                  <= 1'b1;
         widthWord                  <= 1'b1;
         progSupplyHigh             <= 1'b0;
         idVoltHigh                 <= 1'b0;
         data_lines_low_o           <= 15'h0000;
         data_lines_low_oe_n        <= 15'h7fff;
         top_data_or_lane_addr_o    <= 1'b0;
         top_data_or_lane_addr_oe_n <= 1'b1;
      end else if (clkEn) begin
         rspValid <= 1'b0;
         if (!cntDone) cnt_q <= cnt_q - 16'h0001;
         case (state_q)
            OTPH_IDLE: begin
               cmdReady <= 1'b1;
               if (cmdValid && cmdReady) begin
                  cmdReady <= 1'b0;
                  kind_q   <= cmdKind;
                  addr_q   <= cmdAddr;
                  last_q   <= cmdLastAddr;
                  wdata_q  <= cmdData;
                  byte_q   <= cmdByte && (cmdKind == OTPH_CMD_READ);
                  lane_q   <= cmdLane;
                  bad_q    <= 1'b0;
                  tries_q  <= 5'h00;
                  cnt_q    <= 16'(`OTPH_SETTLE_CYC);
                  case (cmdKind)
                     OTPH_CMD_READ: begin
                        // byte width grounds the width pin, top pin is lane
                        widthWord                  <= !cmdByte;
                        word_addr_lines            <= cmdAddr;
                        top_data_or_lane_addr_o    <= cmdLane;
                        top_data_or_lane_addr_oe_n <= !cmdByte;
                        state_q                    <= OTPH_RSETUP;
                     end
                     OTPH_CMD_ID: begin
                        widthWord       <= 1'b1;
                        idVoltHigh      <= 1'b1;
                        word_addr_lines <= idAddr;
                        state_q         <= OTPH_RSETUP;
                     end
                     OTPH_CMD_PROG: begin
                        widthWord      <= 1'b1;
                        progSupplyHigh <= 1'b1;
                        outDriveN      <= 1'b1;
                        state_q        <= OTPH_PSETUP;
                     end
                     default: begin
                        widthWord <= 1'b1;
                        state_q   <= OTPH_FSETUP;
                     end
                  endcase
               end
            end
            OTPH_RSETUP: if (cntDone) begin
               chipSelN  <= 1'b0;
               outDriveN <= 1'b0;
               cnt_q     <= 16'(`OTPH_READ_CYC);
               state_q   <= OTPH_RWAIT;
            end
            OTPH_RWAIT: if (cntDone) begin
               rspValid    <= 1'b1;
               rspData     <= pinData;
               rspParityOk <= oddPar;
               rspError    <= 1'b0;
               if (cmdValid && kind_q == OTPH_CMD_READ && cmdKind == OTPH_CMD_READ
                   && cmdByte == byte_q
                   && cmdAddr[ADDR_W-1:3] == addr_q[ADDR_W-1:3]) begin
                  // same page, keep select low, move low bits only
                  addr_q                  <= cmdAddr;
                  word_addr_lines         <= cmdAddr;
                  lane_q                  <= cmdLane;
                  top_data_or_lane_addr_o <= cmdLane;
                  cnt_q                   <= 16'(`OTPH_PAGE_CYC);
               end else begin
                  chipSelN   <= 1'b1;
                  outDriveN  <= 1'b1;
                  idVoltHigh <= 1'b0;
                  top_data_or_lane_addr_oe_n <= 1'b1;
                  widthWord  <= 1'b1;
                  state_q    <= OTPH_DONE;
               end
            end
            OTPH_PSETUP: begin
               // address and full word settle before the pulse
               word_addr_lines            <= addr_q;
               data_lines_low_o           <= wdata_q[14:0];
               top_data_or_lane_addr_o    <= wdata_q[15];
               data_lines_low_oe_n        <= 15'h0000;
               top_data_or_lane_addr_oe_n <= 1'b0;
               if (cntDone) begin
                  chipSelN <= 1'b0;
                  tries_q  <= tries_q + 5'h01;
                  cnt_q    <= 16'(PULSE_CYC - 1);
                  state_q  <= OTPH_PPULSE;
               end
            end
            OTPH_PPULSE: if (cntDone) begin
               chipSelN                   <= 1'b1;
               data_lines_low_oe_n        <= 15'h7fff;
               top_data_or_lane_addr_oe_n <= 1'b1;
               cnt_q                      <= 16'(`OTPH_SETTLE_CYC);
               state_q                    <= OTPH_PVSETUP;
            end
            OTPH_PVSETUP: if (cntDone) begin
               outDriveN <= 1'b0;
               cnt_q     <= 16'(`OTPH_READ_CYC);
               state_q   <= OTPH_PVWAIT;
            end
            OTPH_PVWAIT: if (cntDone) begin
               outDriveN <= 1'b1;
               cnt_q     <= 16'(`OTPH_SETTLE_CYC);
               if (!match && tries_q < 5'(MAX_PULSES)) begin
                  state_q <= OTPH_PSETUP;
               end else begin
                  bad_q   <= bad_q | !match;
                  tries_q <= 5'h00;
                  if (lastAddr) begin
                     progSupplyHigh <= 1'b0;
                     addr_q         <= cmdAddr;
                     rspValid       <= 1'b1;
                     rspData        <= pinWord;
                     rspError       <= bad_q | !match;
                     rspParityOk    <= 1'b0;
                     state_q        <= OTPH_DONE;
                  end else begin
                     addr_q  <= addr_q + 1'b1;
                     wdata_q <= cmdData;
                     state_q <= OTPH_PSETUP;
                  end
               end
            end
            OTPH_FSETUP: begin
               word_addr_lines <= addr_q;
               if (cntDone) begin
                  chipSelN  <= 1'b0;
                  outDriveN <= 1'b0;
                  cnt_q     <= 16'(`OTPH_READ_CYC);
                  state_q   <= OTPH_FWAIT;
               end
            end
            OTPH_FWAIT: if (cntDone) begin
               bad_q <= bad_q | (pinWord != wdata_q);
               cnt_q <= 16'(`OTPH_SETTLE_CYC);
               if (lastAddr) begin
                  chipSelN  <= 1'b1;
                  outDriveN <= 1'b1;
                  rspValid  <= 1'b1;
                  rspData   <= pinWord;
                  rspError  <= bad_q | (pinWord != wdata_q);
                  state_q   <= OTPH_DONE;
               end else begin
                  addr_q  <= addr_q + 1'b1;
                  wdata_q <= cmdData;
                  state_q <= OTPH_FSETUP;
                  if (&addr_q[2:0]) begin
                     // leaving the page: deselect before the upper address moves
                     chipSelN  <= 1'b1;
                     outDriveN <= 1'b1;
                  end
               end
            end
            OTPH_DONE: state_q <= OTPH_IDLE;
            default:   state_q <= OTPH_IDLE;
         endcase
      end
   end
endmodule : otprom_host
`default_nettype wire

/* tb/otprom_host_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module otprom_host_monitor #(
   parameter int ADDR_W     = 19,
   parameter int PULSE_CYC  = 500,
   parameter int MAX_PULSES = 25
) (
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              reset_n,
   // device pins
   input wire logic [ADDR_W-1:0] word_addr_lines,
   input wire logic              chipSelN,
   input wire logic              outDriveN,
   input wire logic              widthWord,
   input wire logic              progSupplyHigh,
   input wire logic              idVoltHigh,
   input wire logic [14:0]       data_lines_low_oe_n,
   input wire logic              top_data_or_lane_addr_oe_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   int                lowCnt_q;
   int                pulseCnt_q;
   logic [ADDR_W-1:0] addrSeen_q;
   // pulse length and pulses spent on the current address
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lowCnt_q   <= 0;
         pulseCnt_q <= 0;
         addrSeen_q <= '0;
      end else begin
         lowCnt_q   <= chipSelN ? 0 : lowCnt_q + 1;
         addrSeen_q <= word_addr_lines;
         if (addrSeen_q != word_addr_lines) pulseCnt_q <= 0;
         else if (progSupplyHigh && $fell(chipSelN)) pulseCnt_q <= pulseCnt_q + 1;
      end
   end
   a_pulse_width: assert property (
      $rose(chipSelN) && progSupplyHigh && outDriveN |-> lowCnt_q == PULSE_CYC)
      else $error("program pulse length wrong");
   a_prog_odrive: assert property (
      progSupplyHigh && !chipSelN |-> outDriveN) else $error("output drive low in pulse");
   a_prog_data: assert property (
      progSupplyHigh && !chipSelN |-> data_lines_low_oe_n == '0 && !top_data_or_lane_addr_oe_n)
      else $error("data not driven in pulse");
   a_pulse_settled: assert property (
      $fell(chipSelN) && progSupplyHigh |-> $past(word_addr_lines, 2) == word_addr_lines)
      else $error("address not settled before pulse");
   a_pulse_limit: assert property (
      pulseCnt_q <= MAX_PULSES) else $error("too many pulses on one address");
   a_verify_deselect: assert property (
      progSupplyHigh && !outDriveN |-> chipSelN) else $error("verify with select low");
   a_read_nominal: assert property (
      !chipSelN && !outDriveN |-> !progSupplyHigh) else $error("read at programming level");
   a_id_lines_low: assert property (
      idVoltHigh |-> {word_addr_lines[ADDR_W-1:10], word_addr_lines[8:1]} == '0)
      else $error("address lines high in id read");
   a_page_upper: assert property (
      !chipSelN && $past(chipSelN) == 1'b0 && !progSupplyHigh
         |-> $stable(word_addr_lines[ADDR_W-1:3]))
      else $error("page read left its page");
   a_lane_driven: assert property (
      !widthWord && !chipSelN |-> !top_data_or_lane_addr_oe_n) else $error("lane bit floating");
   a_no_contention: assert property (
      !outDriveN |-> &data_lines_low_oe_n) else $error("host drives while device outputs");
endmodule : otprom_host_monitor
bind otprom_host otprom_host_monitor #(.ADDR_W(ADDR_W), .PULSE_CYC(PULSE_CYC),
   .MAX_PULSES(MAX_PULSES)) u_otprom_host_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
   .word_addr_lines(word_addr_lines), .chipSelN(chipSelN), .outDriveN(outDriveN),
   .widthWord(widthWord), .progSupplyHigh(progSupplyHigh), .idVoltHigh(idVoltHigh),
   .data_lines_low_oe_n(data_lines_low_oe_n),
   .top_data_or_lane_addr_oe_n(top_data_or_lane_addr_oe_n));
`default_nettype wire

/* tb/otprom_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module otprom_dev_model #(
   parameter logic [15:0] MAKER_CODE = 16'h0045, // arbitrary value, odd parity
   parameter logic [15:0] PART_CODE  = 16'h8033  // arbitrary value, odd parity
) (
   // address and control
   input wire logic [18:0] addrLines,
   input wire logic        chipSelN,
   input wire logic        outDriveN,
   input wire logic        widthWord,
   input wire logic        progSupplyHigh,
   input wire logic        idVoltHigh,
   input wire logic [4:0]  pulsesNeeded,
   // data pins
   input wire logic [15:0] pinWord,
   output logic [15:0]     devData,
   output logic [15:0]     devOe
);
   logic [15:0] mem [int];
   int          hits [int];
   logic [15:0] word;
   // cells take only after pulsesNeeded pulses, so retries are exercised
   always @(negedge chipSelN) begin
      if (progSupplyHigh && outDriveN) begin
         hits[addrLines] = hits.exists(addrLines) ? hits[addrLines] + 1 : 1;
         if (hits[addrLines] >= pulsesNeeded)
            mem[addrLines] = (mem.exists(addrLines) ? mem[addrLines] : 16'hffff) & pinWord;
      end
   end
   // purely combinational read path
   always @* begin
      word = mem.exists(addrLines) ? mem[addrLines] : 16'hffff;
      if (idVoltHigh) word = addrLines[0] ? PART_CODE : MAKER_CODE;
      devOe = {16{!outDriveN && (!chipSelN || progSupplyHigh)}};
      devData = word;
      if (!widthWord) begin
         devOe[15:8] = 8'h00;
         devData = {8'h00, pinWord[15] ? word[15:8] : word[7:0]};
      end
   end
endmodule : otprom_dev_model
`default_nettype wire

/* tb/otprom_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module otprom_host_tb;
   import otprom_host_pkg::*;
   localparam logic [15:0] MAKER = 16'h0045; // arbitrary value, odd parity
   localparam logic [15:0] PART  = 16'h8033; // arbitrary value, odd parity
   logic        sys_clk = 0, reset_n = 0, cmdValid = 0, cmdByte = 0, cmdLane = 0, rangeMode = 0;
   otph_cmd_t   cmdKind = OTPH_CMD_READ;
   logic [18:0] cmdAddr = '0, cmdLastAddr = '0, word_addr_lines, base, addr;
   logic [15:0] cmdData, rndBase, rspData, pinWord, devData, devOe, w, floatVal = 16'ha5a5;
   logic [4:0]  pulsesNeeded = 5'd1;
   logic        cmdReady, rspValid, rspError, rspParityOk, chipSelN, outDriveN, widthWord;
   logic        progSupplyHigh, idVoltHigh, topO, topOeN;
   logic [14:0] lowO, lowOeN;
   logic [15:0] refMem [int];
   int          fails = 0, checks_done = 0, seed = 32'h9b2a8635;
   function automatic logic [15:0] dataFor(logic [18:0] a);
      return rndBase ^ {a[7:0], ~a[7:0]};
   endfunction : dataFor
   function automatic logic [15:0] refRd(logic [18:0] a);
      return refMem.exists(a) ? refMem[a] : 16'hffff;
   endfunction : refRd
   // range commands take the next word as the address advances past the current one
   assign cmdData = rangeMode ? dataFor(cmdReady ? cmdAddr : word_addr_lines + 19'h1)
                              : 16'h0000;
   // undriven pins change every cycle
   assign pinWord = (~{topOeN, lowOeN} & {topO, lowO}) | ({topOeN, lowOeN} & devOe & devData)
                  | ({topOeN, lowOeN} & ~devOe & floatVal);
   always @(negedge sys_clk) floatVal <= ~floatVal;
   always #50 sys_clk = ~sys_clk;
   otprom_host #(.PULSE_CYC(5)) u_otprom_host (.sys_clk(sys_clk), .reset_n(reset_n),
      .clkEn(1'b1), .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr),
      .cmdLastAddr(cmdLastAddr), .cmdByte(cmdByte), .cmdLane(cmdLane), .cmdData(cmdData),
      .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
      .rspParityOk(rspParityOk), .word_addr_lines(word_addr_lines), .chipSelN(chipSelN),
      .outDriveN(outDriveN), .widthWord(widthWord), .progSupplyHigh(progSupplyHigh),
      .idVoltHigh(idVoltHigh), .data_lines_low_o(lowO), .data_lines_low_oe_n(lowOeN),
      .data_lines_low_i(pinWord[14:0]), .top_data_or_lane_addr_o(topO),
      .top_data_or_lane_addr_oe_n(topOeN), .top_data_or_lane_addr_i(pinWord[15]));
   otprom_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_otprom_dev_model (
      .addrLines(word_addr_lines), .chipSelN(chipSelN), .outDriveN(outDriveN),
      .widthWord(widthWord), .progSupplyHigh(progSupplyHigh), .idVoltHigh(idVoltHigh),
      .pulsesNeeded(pulsesNeeded), .pinWord(pinWord), .devData(devData), .devOe(devOe));
   task automatic check(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic wait_rsp;
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (rspValid !== 1'b1 && n < 5000);
      if (n >= 5000) check("rspValid", 16'h0000, 16'h0001);
   endtask : wait_rsp
   // a2 differing from a keeps the request up as a follow-on page read
   task automatic run_cmd(input otph_cmd_t kind, input logic [18:0] a, last, a2,
                          input logic byteW, lane, input logic [15:0] exp, exp2,
                          input logic expErr);
      int n;
      n = 0;
      @(negedge sys_clk);
      cmdKind = kind;
      cmdAddr = a;
      cmdLastAddr = last;
      cmdByte = byteW;
      cmdLane = lane;
      cmdValid = 1'b1;
      rangeMode = kind inside {OTPH_CMD_PROG, OTPH_CMD_FVER};
      while (cmdReady !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      cmdValid = (a2 !== a);
      cmdAddr = a2;
      wait_rsp();
      if (kind == OTPH_CMD_READ || kind == OTPH_CMD_ID) check("rspData", rspData, exp);
      else check("rspError", {15'h0, rspError}, {15'h0, expErr});
      if (kind == OTPH_CMD_ID) check("rspParityOk", {15'h0, rspParityOk}, 16'h0001);
      if (cmdValid) begin
         // the follow-on read was taken with the first answer
         cmdValid = 1'b0;
         wait_rsp();
         check("pageData", rspData, exp2);
      end
      cmdValid = 1'b0;
      rangeMode = 1'b0;
   endtask : run_cmd
   initial begin
      #3000000;
      fails++;
      finish_test();
   end
   initial begin
      rndBase = 16'($random(seed));
      base = 19'($random(seed)) & 19'h7fff0;
      repeat (10) @(negedge sys_clk);
      check("chipSelN", {15'h0, chipSelN}, 16'h0001);
      repeat (10) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      run_cmd(OTPH_CMD_READ, base + 1, 0, base + 6, 0, 0, 16'hffff, 16'hffff, 0);
      pulsesNeeded = 5'd3;
      run_cmd(OTPH_CMD_PROG, base, base + 3, base, 0, 0, 0, 0, 0);
      for (int i = 0; i < 4; i++) refMem[base + i] = dataFor(base + i);
      run_cmd(OTPH_CMD_FVER, base, base + 3, base, 0, 0, 0, 0, 0);
      run_cmd(OTPH_CMD_READ, base + 2, 0, base + 3, 0, 0, refRd(base + 2), refRd(base + 3), 0);
      w = refRd(base + 1);
      for (int l = 0; l < 2; l++)
         run_cmd(OTPH_CMD_READ, base + 1, 0, base + 1, 1, l[0], l ? {8'h00, w[15:8]}
                 : {8'h00, w[7:0]}, 0, 0);
      for (int i = 0; i < 2; i++)
         run_cmd(OTPH_CMD_ID, 19'(i), 0, 19'(i), 0, 0, i ? PART : MAKER, 0, 0);
      pulsesNeeded = 5'd26;
      run_cmd(OTPH_CMD_PROG, base + 8, base + 9, base + 8, 0, 0, 0, 0, 1);
      run_cmd(OTPH_CMD_FVER, base + 8, base + 9, base + 8, 0, 0, 0, 0, 1);
      run_cmd(OTPH_CMD_READ, base + 8, 0, base + 8, 0, 0, 16'hffff, 0, 0);
      for (int i = 0; i < 4; i++) begin
         addr = base + 19'($random(seed) & 7);
         run_cmd(OTPH_CMD_READ, addr, 0, addr ^ 19'h5, 0, 0, refRd(addr),
                 refRd(addr ^ 19'h5), 0);
      end
      finish_test();
   end
endmodule : otprom_host_tb
`default_nettype wire
